/* File: include/rsc_consts.svh */
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH

// --------------------------------------------------------------------------
// Register byte addresses
// --------------------------------------------------------------------------
`define RSC_ADDR_FTW0        16'h0300
`define RSC_ADDR_FTW5        16'h0305
`define RSC_ADDR_SLEW_LO     16'h0316
`define RSC_ADDR_SLEW_HI     16'h0317
`define RSC_ADDR_PBO         16'h0507
`define RSC_ADDR_LOOP        16'h0a01

// --------------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------------
`define RSC_LOOP_UREF_LSB    0
`define RSC_LOOP_MODE_LSB    3
`define RSC_LOOP_FREE_BIT    5
`define RSC_LOOP_HOLD_BIT    6
`define RSC_PBO_THR_LSB      0
`define RSC_LOOP_RESET       8'h00
`define RSC_PBO_RESET        8'h00
`define RSC_SLEW_RESET       16'h0000
`define RSC_FTW_RESET        48'h000000000000

// --------------------------------------------------------------------------
// Timing: one picosecond of slew credit per accumulated unit threshold
// --------------------------------------------------------------------------
`define RSC_CLK_PERIOD_NS    10
`define RSC_PS_PER_NS        1000
`define RSC_NS_PER_S         1000000000
`define RSC_SLEW_CREDIT      (`RSC_NS_PER_S / `RSC_PS_PER_NS)

`endif

/* File: include/rsc_pkg.sv */
package rsc_pkg;

    typedef enum logic [1:0] {
        MODE_AUTO     = 2'h0,
        MODE_FALLBACK = 2'h1,
        MODE_HOLDOVER = 2'h2,
        MODE_MANUAL   = 2'h3
    } rsc_mode_t;

    typedef enum logic [2:0] {
        LS_FREERUN  = 3'h1,
        LS_HOLDOVER = 3'h2,
        LS_ACTIVE   = 3'h4
    } rsc_loop_t;

endpackage

/* File: include/rsc_slew_if.sv */
`timescale 1ns/100ps
interface rsc_slew_if;
    logic [15:0]        limit;
    logic               switch_start;
    logic signed [31:0] phase_err;
    logic               step_up;
    logic               step_dn;
    logic               active;

    modport ctrl    (output limit, switch_start, phase_err,
                     input  step_up, step_dn, active);
    modport limiter (input  limit, switch_start, phase_err,
                     output step_up, step_dn, active);
endinterface

/* File: rtl/rsc_slew_limit.sv */
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_slew_limit
    import rsc_pkg::*;
(
    input wire logic  mclk,
    input wire logic  srst,
    rsc_slew_if.limiter sif
);
    localparam logic [23:0] CREDIT  = 24'(`RSC_SLEW_CREDIT);
    localparam logic [23:0] PER_CLK = 24'(`RSC_CLK_PERIOD_NS);

    logic [23:0] acc;
    logic [15:0] credit;
    logic        take;

    assign take = sif.active && (sif.limit != 16'h0) && (credit != 16'h0) &&
                  (sif.phase_err != 32'sh0);

    // Budget accrues at limit ns/s; each full credit allows one 1 ps step.
    always_ff @(posedge mclk) begin
        if (srst || !sif.active) begin
            acc    <= 24'h0;
            credit <= 16'h0;
        end else if (acc + sif.limit * PER_CLK >= CREDIT) begin
            acc    <= acc + sif.limit * PER_CLK - CREDIT;
            credit <= credit + 16'h1 - {15'h0, take};
        end else begin
            acc    <= acc + sif.limit * PER_CLK;
            credit <= credit - {15'h0, take};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || sif.limit == 16'h0) begin
            sif.active <= 1'b0;
        end else if (sif.switch_start) begin
            sif.active <= 1'b1;
        end else if (sif.phase_err == 32'sh0) begin
            sif.active <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sif.step_up <= 1'b0;
            sif.step_dn <= 1'b0;
        end else begin
            sif.step_up <= take && !sif.phase_err[31];
            sif.step_dn <= take && sif.phase_err[31];
        end
    end

    a_slew_disabled: assert property (@(posedge mclk) disable iff (srst)
        sif.limit == 16'h0 |=> !sif.active && !sif.step_up && !sif.step_dn)
        else $error("slew controller active with zero limit");
    a_step_needs_credit: assert property (@(posedge mclk) disable iff (srst)
        (sif.step_up || sif.step_dn) |-> $past(credit) != 16'h0 && $past(sif.active))
        else $error("phase step taken without slew credit");
    a_slew_start: assert property (@(posedge mclk) disable iff (srst)
        sif.switch_start && sif.limit != 16'h0 |=> sif.active)
        else $error("slew controller did not start on a switchover");
    a_slew_settle: assert property (@(posedge mclk) disable iff (srst)
        sif.active && !sif.switch_start && sif.phase_err == 32'sh0 |=> !sif.active)
        else $error("slew controller kept running with no phase error");
endmodule

/* File: rtl/rsc_top.sv */
`timescale 1ns/100ps
`include "rsc_consts.svh"
module rsc_top
    import rsc_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic [15:0]        reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_we,
    output logic      [7:0]         reg_rdata,
    input  wire logic [3:0]         ref_valid,
    input  wire logic [3:0]         redetect_expired,
    input  wire logic [3:0]         prof_load,
    input  wire logic [11:0]        prof_num,
    input  wire logic [23:0]        sel_prio_tab,
    input  wire logic [23:0]        promo_prio_tab,
    input  wire logic signed [31:0] phase_err,
    output logic      [1:0]         active_ref,
    output rsc_loop_t               loop_state,
    output logic                    switch_pulse,
    output logic                    buildout_pulse,
    output logic      [47:0]        ftw_out,
    output logic                    slew_active,
    output logic                    slew_step_up,
    output logic                    slew_step_dn
);
    // ----------------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------------
    function automatic logic [2:0] prio_of(input logic [2:0] prof,
                                           input logic [23:0] tab);
        prio_of = tab[prof*3 +: 3];
    endfunction

    function automatic logic [5:0] best_pick(input logic [3:0]  cand,
                                             input logic [11:0] pn,
                                             input logic [23:0] sp);
        logic       found;
        logic [1:0] idx;
        logic [2:0] pr;
        logic [2:0] p;
        found = 1'b0;
        idx   = 2'h0;
        pr    = 3'h7;
        // Scanning downward with <= leaves the lowest index on a tie.
        for (int i = 3; i >= 0; i--) begin
            p = prio_of(pn[i*3 +: 3], sp);
            if (cand[i] && (!found || p <= pr)) begin
                found = 1'b1;
                idx   = 2'(i);
                pr    = p;
            end
        end
        best_pick = {found, idx, pr};
    endfunction

    // ----------------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------------
    logic [47:0] free_run_tuning_word;
    logic [15:0] phase_slew_rate_limit;
    logic [7:0]  phase_buildout_switching;
    logic [7:0]  loop_mode;

    always_ff @(posedge mclk) begin
        if (srst) begin
            free_run_tuning_word     <= `RSC_FTW_RESET;
            phase_slew_rate_limit    <= `RSC_SLEW_RESET;
            phase_buildout_switching <= `RSC_PBO_RESET;
            loop_mode                <= `RSC_LOOP_RESET;
        end else if (reg_we) begin
            if (reg_addr >= `RSC_ADDR_FTW0 && reg_addr <= `RSC_ADDR_FTW5) begin
                free_run_tuning_word[(reg_addr[2:0])*8 +: 8] <= reg_wdata;
            end
            if (reg_addr == `RSC_ADDR_SLEW_LO) begin
                phase_slew_rate_limit[7:0] <= reg_wdata;
            end
            if (reg_addr == `RSC_ADDR_SLEW_HI) begin
                phase_slew_rate_limit[15:8] <= reg_wdata;
            end
            if (reg_addr == `RSC_ADDR_PBO) begin
                phase_buildout_switching <= reg_wdata;
            end
            if (reg_addr == `RSC_ADDR_LOOP) begin
                loop_mode <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_addr >= `RSC_ADDR_FTW0 && reg_addr <= `RSC_ADDR_FTW5) begin
            reg_rdata <= free_run_tuning_word[(reg_addr[2:0])*8 +: 8];
        end else if (reg_addr == `RSC_ADDR_SLEW_LO) begin
            reg_rdata <= phase_slew_rate_limit[7:0];
        end else if (reg_addr == `RSC_ADDR_SLEW_HI) begin
            reg_rdata <= phase_slew_rate_limit[15:8];
        end else if (reg_addr == `RSC_ADDR_PBO) begin
            reg_rdata <= phase_buildout_switching;
        end else if (reg_addr == `RSC_ADDR_LOOP) begin
            reg_rdata <= loop_mode;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ----------------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------------
    rsc_mode_t  sel_mode;
    logic [1:0] user_ref;
    logic       force_free;
    logic       force_hold;
    logic [2:0] pm_thresh;

    assign sel_mode   = rsc_mode_t'(loop_mode[`RSC_LOOP_MODE_LSB +: 2]);
    assign user_ref   = loop_mode[`RSC_LOOP_UREF_LSB +: 2];
    assign force_free = loop_mode[`RSC_LOOP_FREE_BIT];
    assign force_hold = loop_mode[`RSC_LOOP_HOLD_BIT];
    assign pm_thresh  = phase_buildout_switching[`RSC_PBO_THR_LSB +: 3];

    // ----------------------------------------------------------------------
    // Reference-to-profile table
    // ----------------------------------------------------------------------
    logic [3:0]  prof_ok;
    logic [11:0] prof_tab;

    always_ff @(posedge mclk) begin
        if (srst) begin
            prof_ok  <= 4'h0;
            prof_tab <= 12'h000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (prof_load[i]) begin
                    prof_ok[i]        <= 1'b1;
                    prof_tab[i*3 +: 3] <= prof_num[i*3 +: 3];
                end else if (redetect_expired[i]) begin
                    prof_ok[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // Selection
    // ----------------------------------------------------------------------
    logic [3:0] cand;
    logic [5:0] best;
    logic       best_found;
    logic [1:0] best_idx;
    logic [2:0] best_prio;
    logic       user_ok;
    logic       act_ok;
    logic [2:0] act_promo;
    logic [1:0] next_ref;
    rsc_loop_t  next_state;
    logic       next_switch;
    logic       next_master;

    assign cand       = ref_valid & prof_ok;
    assign best       = best_pick(cand, prof_tab, sel_prio_tab);
    assign best_found = best[5];
    assign best_idx   = best[4:3];
    assign best_prio  = best[2:0];
    assign user_ok    = cand[user_ref];
    assign act_ok     = (loop_state == LS_ACTIVE) && cand[active_ref];
    assign act_promo  = prio_of(prof_tab[active_ref*3 +: 3], promo_prio_tab);

    always_comb begin
        next_ref   = active_ref;
        next_state = loop_state;
        if (force_free) begin
            next_state = LS_FREERUN;
        end else if (force_hold) begin
            next_state = LS_HOLDOVER;
        end else begin
            unique case (sel_mode)
                MODE_MANUAL: begin
                    next_state = LS_ACTIVE;
                    next_ref   = user_ref;
                end
                MODE_HOLDOVER: begin
                    if (user_ok) begin
                        next_state = LS_ACTIVE;
                        next_ref   = user_ref;
                    end else begin
                        next_state = LS_HOLDOVER;
                    end
                end
                MODE_FALLBACK, MODE_AUTO: begin
                    if (sel_mode == MODE_FALLBACK && user_ok) begin
                        next_state = LS_ACTIVE;
                        next_ref   = user_ref;
                    end else if (!act_ok) begin
                        next_state = best_found ? LS_ACTIVE : LS_HOLDOVER;
                        next_ref   = best_found ? best_idx : active_ref;
                    end else if (best_found && best_prio < act_promo) begin
                        next_state = LS_ACTIVE;
                        next_ref   = best_idx;
                    end
                end
            endcase
        end
    end

    assign next_switch = (next_state == LS_ACTIVE) &&
                         (loop_state != LS_ACTIVE || next_ref != active_ref);
    assign next_master = prio_of(prof_tab[next_ref*3 +: 3], sel_prio_tab) < pm_thresh;

    always_ff @(posedge mclk) begin
        if (srst) begin
            active_ref     <= 2'h0;
            loop_state     <= LS_FREERUN;
            switch_pulse   <= 1'b0;
            buildout_pulse <= 1'b0;
        end else begin
            active_ref     <= next_ref;
            loop_state     <= next_state;
            switch_pulse   <= next_switch;
            buildout_pulse <= next_switch && !next_master;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ftw_out <= `RSC_FTW_RESET;
        end else if (next_state == LS_FREERUN) begin
            ftw_out <= free_run_tuning_word;
        end
    end

    // ----------------------------------------------------------------------
    // Phase slew limiter
    // ----------------------------------------------------------------------
    rsc_slew_if slew_bus();

    assign slew_bus.limit        = phase_slew_rate_limit;
    assign slew_bus.switch_start = switch_pulse;
    assign slew_bus.phase_err    = phase_err;
    assign slew_active           = slew_bus.active;
    assign slew_step_up          = slew_bus.step_up;
    assign slew_step_dn          = slew_bus.step_dn;

    rsc_slew_limit u_slew (
        .mclk (mclk),
        .srst (srst),
        .sif  (slew_bus.limiter)
    );

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    a_manual_user_ref: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_MANUAL && !force_free && !force_hold
        |=> active_ref == $past(user_ref) && loop_state == LS_ACTIVE)
        else $error("manual mode did not select the user reference");
    a_hold_on_invalid: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_HOLDOVER && !force_free && !force_hold && !user_ok
        |=> loop_state == LS_HOLDOVER)
        else $error("holdover mode failed to hold on invalid user reference");
    a_force_freerun: assert property (@(posedge mclk) disable iff (srst)
        force_free |=> loop_state == LS_FREERUN ##0 ftw_out == $past(free_run_tuning_word))
        else $error("forced free-run not applied");
    a_switch_valid: assert property (@(posedge mclk) disable iff (srst)
        switch_pulse && $past(sel_mode) != MODE_MANUAL
        |-> ($past(cand) & (4'h1 << active_ref)) != 4'h0)
        else $error("switched to an invalid reference");
    a_auto_best: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_AUTO && !force_free && !force_hold && !act_ok && best_found
        |=> active_ref == $past(best_idx))
        else $error("automatic switch missed the best reference");
    a_fallback_user: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_FALLBACK && !force_free && !force_hold && user_ok
        |=> active_ref == $past(user_ref) && loop_state == LS_ACTIVE)
        else $error("fallback mode ignored a valid user reference");
    a_buildout_switch: assert property (@(posedge mclk) disable iff (srst)
        buildout_pulse |-> switch_pulse &&
        prio_of(prof_tab[active_ref*3 +: 3], sel_prio_tab) >= $past(pm_thresh))
        else $error("build-out switch to a phase master");
    a_thresh_reset: assert property (@(posedge mclk)
        srst |=> pm_thresh == 3'h0 && phase_slew_rate_limit == 16'h0)
        else $error("threshold or slew limit not cleared by reset");
    a_null_expire: assert property (@(posedge mclk) disable iff (srst)
        (redetect_expired & ~prof_load) != 4'h0
        |=> (prof_ok & $past(redetect_expired & ~prof_load)) == 4'h0)
        else $error("profile not cleared on redetect expiry");
    a_force_holdover: assert property (@(posedge mclk) disable iff (srst)
        !force_free && force_hold |=> loop_state == LS_HOLDOVER)
        else $error("forced holdover not applied");
    a_hold_user_ok: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_HOLDOVER && !force_free && !force_hold && user_ok
        |=> active_ref == $past(user_ref) && loop_state == LS_ACTIVE)
        else $error("holdover mode ignored a valid user reference");
    a_no_cand_hold: assert property (@(posedge mclk) disable iff (srst)
        (sel_mode == MODE_AUTO || sel_mode == MODE_FALLBACK) && !force_free && !force_hold
        && cand == 4'h0 |=> loop_state == LS_HOLDOVER)
        else $error("no candidate left but loop not in holdover");

    // A returning reference no better than the promoted priority must not take over.
    a_promo_keeps: assert property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_AUTO && !force_free && !force_hold && act_ok && best_found
        && best_prio >= act_promo |=> active_ref == $past(active_ref) && !switch_pulse)
        else $error("promoted priority did not keep the active reference");
    a_tuning_frozen: assert property (@(posedge mclk) disable iff (srst)
        next_state != LS_FREERUN |=> $stable(ftw_out))
        else $error("tuning word output moved outside free-run");
    a_loop_onehot: assert property (@(posedge mclk) disable iff (srst)
        $onehot(loop_state))
        else $error("loop state is not a legal one-hot code");

    c_auto_switch: cover property (@(posedge mclk) disable iff (srst)
        sel_mode == MODE_AUTO ##1 switch_pulse);
    c_buildout: cover property (@(posedge mclk) disable iff (srst) buildout_pulse);
    c_promo_block: cover property (@(posedge mclk) disable iff (srst)
        act_ok && best_found && best_idx != active_ref && best_prio >= act_promo);
    c_slew_run: cover property (@(posedge mclk) disable iff (srst) slew_step_up);
    c_hold_entry: cover property (@(posedge mclk) disable iff (srst)
        loop_state == LS_ACTIVE ##1 loop_state == LS_HOLDOVER);
endmodule

/* File: tb/rsc_ref_src.sv */
`timescale 1ns/100ps
module rsc_ref_src (
    input  wire logic        mclk,
    input  wire logic [3:0]  want_valid,
    input  wire logic [11:0] want_prof,
    input  wire logic [3:0]  load_req,
    input  wire logic [3:0]  expire_req,
    output logic      [3:0]  ref_valid,
    output logic      [11:0] prof_num,
    output logic      [3:0]  prof_load,
    output logic      [3:0]  redetect_expired
);
    initial begin
        ref_valid        = 4'h0;
        prof_num         = 12'h000;
        prof_load        = 4'h0;
        redetect_expired = 4'h0;
    end

    // Profile numbers are only meaningful during a load, so they toggle otherwise.
    always @(posedge mclk) begin
        ref_valid        <= want_valid;
        prof_load        <= load_req;
        prof_num         <= (|load_req) ? want_prof : ~prof_num;
        redetect_expired <= expire_req;
    end
endmodule

/* File: tb/reference_switchover_control_tb.sv */
`timescale 1ns/100ps
`include "rsc_consts.svh"
module reference_switchover_control_tb;
    import rsc_pkg::*;
    typedef struct { int kind; string name; logic [47:0] exp; } rsc_note_t;
    logic               mclk, srst, reg_we, chk_go, switch_pulse, buildout_pulse;
    logic               slew_active, slew_step_up, slew_step_dn, bo_seen, step_seen, sw_seen;
    logic [15:0]        reg_addr;
    logic [7:0]         reg_wdata, reg_rdata;
    logic [3:0]         want_valid, load_req, expire_req, ref_valid, prof_load, redetect_expired;
    logic [11:0]        want_prof, prof_num;
    logic [23:0]        sel_tab, promo_tab;
    logic signed [31:0] phase_err;
    logic [1:0]         active_ref, prev_r;
    rsc_loop_t          loop_state, prev_ls;
    logic [47:0]        ftw_out, ftw;
    int                 err_count, num_checks, i;
    bit [31:0]          rng;
    rsc_note_t          notes[$];
    rsc_note_t          n;

    rsc_ref_src rsc_ref_src_inst (.mclk(mclk), .want_valid(want_valid), .want_prof(want_prof),
        .load_req(load_req), .expire_req(expire_req), .ref_valid(ref_valid),
        .prof_num(prof_num), .prof_load(prof_load), .redetect_expired(redetect_expired));

    rsc_top rsc_top_inst (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_we(reg_we), .reg_rdata(reg_rdata), .ref_valid(ref_valid),
        .redetect_expired(redetect_expired), .prof_load(prof_load), .prof_num(prof_num),
        .sel_prio_tab(sel_tab), .promo_prio_tab(promo_tab), .phase_err(phase_err),
        .active_ref(active_ref), .loop_state(loop_state), .switch_pulse(switch_pulse),
        .buildout_pulse(buildout_pulse), .ftw_out(ftw_out), .slew_active(slew_active),
        .slew_step_up(slew_step_up), .slew_step_dn(slew_step_dn));

    // ----------------------------------------------------------------------
    // Clock, helpers and checking
    // ----------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic bit [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic tick(int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task automatic check(string nm, logic [47:0] seen, logic [47:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic note(int k, string nm, logic [47:0] e);
        notes.push_back('{k, nm, e});
    endtask

    task automatic go();
        chk_go = 1'b1;
        tick(1);
        chk_go = 1'b0;
        tick(1);
    endtask

    task automatic wr(logic [15:0] a, logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_we    = 1'b1;
        tick(1);
        reg_we    = 1'b0;
        tick(1);
    endtask

    task automatic rd(logic [15:0] a, logic [7:0] e);
        reg_addr = a;
        tick(1);
        note(0, "reg_rdata", 48'(e));
        go();
    endtask

    task automatic lm(logic [1:0] m, logic [1:0] u, logic h, logic f);
        wr(`RSC_ADDR_LOOP, {1'b0, h, f, m, 1'b0, u});
    endtask

    // Negative bo or stp means that flag is not judged in this step.
    task automatic st(logic [3:0] v, logic [1:0] r, rsc_loop_t ls, int bo, int stp);
        want_valid = v;
        tick(8);
        if (ls == LS_ACTIVE) begin
            note(1, "active_ref", 48'(r));
            note(7, "switch", 48'(prev_ls != LS_ACTIVE || prev_r != r));
        end
        note(2, "loop_state", 48'(ls));
        if (bo >= 0)
            note(3, "buildout", 48'(bo));
        if (stp >= 0)
            note(4, "slew_step", 48'(stp));
        prev_ls = ls;
        prev_r  = r;
        go();
    endtask

    always @(posedge mclk) begin
        if (srst) begin
            bo_seen   <= 1'b0;
            step_seen <= 1'b0;
            sw_seen   <= 1'b0;
        end else if (chk_go) begin
            while (notes.size() > 0) begin
                n = notes.pop_front();
                case (n.kind)
                    0: check(n.name, 48'(reg_rdata), n.exp);
                    1: check(n.name, 48'(active_ref), n.exp);
                    2: check(n.name, 48'(loop_state), n.exp);
                    3: check(n.name, 48'(bo_seen), n.exp);
                    4: check(n.name, 48'(step_seen), n.exp);
                    5: check(n.name, ftw_out, n.exp);
                    7: check(n.name, 48'(sw_seen), n.exp);
                    default: check(n.name, 48'(slew_active), n.exp);
                endcase
            end
            bo_seen   <= 1'b0;
            step_seen <= 1'b0;
            sw_seen   <= 1'b0;
        end else begin
            if (switch_pulse)
                sw_seen <= 1'b1;
            if (switch_pulse && buildout_pulse)
                bo_seen <= 1'b1;
            if (slew_step_up || slew_step_dn) begin
                step_seen <= 1'b1;
                check("slew_step_up", 48'(slew_step_up), 48'(!phase_err[31]));
                check("slew_step_dn", 48'(slew_step_dn), 48'(phase_err[31]));
            end
        end
    end

    initial begin
        #300000;
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        srst = 1'b1; reg_addr = 16'h0000; reg_wdata = 8'h00; reg_we = 1'b0; chk_go = 1'b0;
        want_valid = 4'h0; want_prof = 12'h000; load_req = 4'h0; expire_req = 4'h0;
        sel_tab   = {3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h7, 3'h2, 3'h3};
        promo_tab = {3'h7, 3'h7, 3'h7, 3'h7, 3'h4, 3'h7, 3'h2, 3'h1};
        err_count = 0; num_checks = 0; rng = 32'd29501;
        prev_ls = LS_HOLDOVER;
        prev_r  = 2'h0;
        phase_err = $signed({16'h0000, 16'(xs())}) + 32'sd1;
        ftw = {16'(xs()), xs()};
        tick(2);
        srst = 1'b0;
        rd(`RSC_ADDR_LOOP, 8'h00);
        rd(`RSC_ADDR_PBO, 8'h00);
        rd(`RSC_ADDR_SLEW_LO, 8'h00);
        rd(`RSC_ADDR_SLEW_HI, 8'h00);
        wr(16'h0123, 8'hff);
        rd(16'h0123, 8'h00);
        $display("test registers done");
        want_prof = {3'h3, 3'h1, 3'h1, 3'h0};
        load_req = 4'hf; tick(1); load_req = 4'h0;
        st(4'hf, 2'h1, LS_ACTIVE, -1, -1);
        st(4'hd, 2'h2, LS_ACTIVE, 1, 0);
        st(4'h9, 2'h0, LS_ACTIVE, 1, 0);
        st(4'hb, 2'h0, LS_ACTIVE, 0, -1);
        st(4'ha, 2'h1, LS_ACTIVE, 1, -1);
        expire_req = 4'h2; tick(1); expire_req = 4'h0;
        st(4'ha, 2'h3, LS_ACTIVE, 1, -1);
        st(4'h0, 2'h0, LS_HOLDOVER, 0, -1);
        load_req = 4'h2; tick(1); load_req = 4'h0;
        st(4'hf, 2'h1, LS_ACTIVE, 1, -1);
        $display("test automatic selection done");
        wr(`RSC_ADDR_PBO, 8'h03);
        rd(`RSC_ADDR_PBO, 8'h03);
        st(4'hd, 2'h2, LS_ACTIVE, 0, -1);
        st(4'h9, 2'h0, LS_ACTIVE, 1, -1);
        wr(`RSC_ADDR_SLEW_LO, 8'hff);
        wr(`RSC_ADDR_SLEW_HI, 8'hff);
        rd(`RSC_ADDR_SLEW_HI, 8'hff);
        st(4'ha, 2'h1, LS_ACTIVE, 0, 1);
        phase_err = 32'sd0;
        tick(4);
        note(6, "slew_active", 48'h0);
        go();
        $display("test build-out and slew done");
        for (i = 0; i < 4; i++) begin
            lm(2'h3, 2'(i), 1'b0, 1'b0);
            st(4'hf, 2'(i), LS_ACTIVE, -1, -1);
        end
        lm(2'h3, 2'h0, 1'b0, 1'b0);
        st(4'he, 2'h0, LS_ACTIVE, -1, -1);
        lm(2'h2, 2'h2, 1'b0, 1'b0);
        st(4'hb, 2'h0, LS_HOLDOVER, -1, -1);
        st(4'hf, 2'h2, LS_ACTIVE, -1, -1);
        lm(2'h1, 2'h3, 1'b0, 1'b0);
        st(4'hf, 2'h3, LS_ACTIVE, -1, -1);
        st(4'h7, 2'h1, LS_ACTIVE, -1, -1);
        lm(2'h0, 2'h3, 1'b0, 1'b0);
        st(4'hf, 2'h1, LS_ACTIVE, -1, -1);
        $display("test modes done");
        for (i = 0; i < 6; i++)
            wr(`RSC_ADDR_FTW0 + 16'(i), ftw[8*i +: 8]);
        lm(2'h0, 2'h0, 1'b1, 1'b0);
        st(4'hf, 2'h0, LS_HOLDOVER, -1, -1);
        lm(2'h0, 2'h0, 1'b0, 1'b1);
        st(4'hf, 2'h0, LS_FREERUN, -1, -1);
        note(5, "ftw_out", ftw);
        go();
        lm(2'h0, 2'h0, 1'b1, 1'b1);
        st(4'hf, 2'h0, LS_FREERUN, -1, -1);
        lm(2'h0, 2'h0, 1'b0, 1'b0);
        st(4'hf, 2'h1, LS_ACTIVE, -1, -1);
        $display("test forced states done");
        report_and_stop();
    end
endmodule
